// *** fsp_fault_status.sv ***
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module fsp_fault_status #(
   parameter int NUM_IRQ = 32
) (
   // clock and reset
   input  wire logic                   CORE_CLK,
   input  wire logic                   RESETN,
   // register port
   input  wire fsp_pkg::fsp_bus_req_t  BUS_REQ,
   output logic [fsp_pkg::DATA_W-1:0]  BUS_RDATA,
   // interrupt sources and acknowledge
   input  wire logic [NUM_IRQ-1:0]     IRQ_REQ,
   input  wire logic                   IRQ_ACK,
   input  wire logic [4:0]             IRQ_ACK_NUM,
   output logic [NUM_IRQ-1:0]          IRQ_PENDING,
   output logic [NUM_IRQ-1:0]          IRQ_ACTIVE_REQ,
   // core fault reports and entry control
   input  wire fsp_pkg::fsp_fault_evt_t FAULT_EVT,
   output fsp_pkg::fsp_entry_ctl_t     ENTRY_CTL
);
   import fsp_pkg::*;

   typedef struct packed {
      logic [NUM_IRQ-1:0] pending;
      logic [NUM_IRQ-1:0] enable;
      logic               unstack_bf;
      logic               entry_stacking_fault;
      logic               bus_fault_addr_valid;
      logic [DATA_W-1:0]  bus_fault_address;
      logic               undecodable_op_fault;
      logic               illegal_state_fault;
      logic               illegal_pc_load_fault;
      logic               vector_read_fault;
      logic               forced;
      logic               debug_reserved_flag;
      logic [DATA_W-1:0]  rdata;
      fsp_entry_ctl_t     entry;
   } fsp_state_t;

   fsp_state_t st;
   fsp_state_t next_st;

   // sticky flag: set wins over write-one clear
   function automatic logic sticky(input logic cur, input logic set, input logic clr);
      sticky = set | (cur & ~clr);
   endfunction

   logic                wr_set_pend;
   logic                wr_enable;
   logic                wr_fault;
   logic                wr_hard;
   logic [DATA_W-1:0]   wd;
   logic [NUM_IRQ-1:0]  ack_mask;
   logic                ill_state_ev;
   logic                any_fault;
   logic                addr_capture;

   always_comb begin
      wd           = BUS_REQ.wdata;
      wr_set_pend  = BUS_REQ.wr && BUS_REQ.addr == OFS_SET_PEND;
      wr_enable    = BUS_REQ.wr && BUS_REQ.addr == OFS_ENABLE;
      wr_fault     = BUS_REQ.wr && BUS_REQ.addr == OFS_FAULT_STAT;
      wr_hard      = BUS_REQ.wr && BUS_REQ.addr == OFS_HARD_STAT;
      ack_mask     = '0;
      if (IRQ_ACK) begin
         ack_mask[IRQ_ACK_NUM] = 1'b1;
      end
      // undefined instruction takes precedence over state misuse
      ill_state_ev = FAULT_EVT.illegal_state & ~FAULT_EVT.undef_instr;
      // no capture on stacking faults, unstack faults, or while stacking flag set
      addr_capture = FAULT_EVT.bus_fault_precise & ~FAULT_EVT.stack_bus_fault
                     & ~FAULT_EVT.unstack_bus_fault & ~st.entry_stacking_fault;
      any_fault    = FAULT_EVT.unstack_bus_fault | FAULT_EVT.stack_bus_fault
                     | FAULT_EVT.bus_fault_precise | FAULT_EVT.mem_fault
                     | FAULT_EVT.undef_instr | FAULT_EVT.illegal_state
                     | FAULT_EVT.illegal_pc_load | FAULT_EVT.forced_escalation
                     | FAULT_EVT.vector_read_fault;

      next_st = st;

      // pending: ones set, zeros ignored, enable not consulted
      next_st.pending = IRQ_REQ | (st.pending & ~ack_mask);
      if (wr_set_pend) begin
         next_st.pending = next_st.pending | wd[NUM_IRQ-1:0];
      end
      if (wr_enable) begin
         next_st.enable = wd[NUM_IRQ-1:0];
      end

      // bus fault subregister
      next_st.unstack_bf = sticky(st.unstack_bf, FAULT_EVT.unstack_bus_fault,
                                  wr_fault & wd[BIT_UNSTACK_BF]);
      next_st.entry_stacking_fault = sticky(st.entry_stacking_fault,
                                            FAULT_EVT.stack_bus_fault,
                                            wr_fault & wd[BIT_STACK_BF]);
      next_st.bus_fault_addr_valid = sticky(st.bus_fault_addr_valid, addr_capture,
                                            (wr_fault & wd[BIT_ADDR_VALID])
                                            | FAULT_EVT.mem_fault);
      if (addr_capture) begin
         next_st.bus_fault_address = FAULT_EVT.bus_addr;
      end

      // usage fault subregister
      next_st.undecodable_op_fault = sticky(st.undecodable_op_fault, FAULT_EVT.undef_instr,
                                            wr_fault & wd[BIT_UNDEF_OP]);
      next_st.illegal_state_fault = sticky(st.illegal_state_fault, ill_state_ev,
                                           wr_fault & wd[BIT_ILL_STATE]);
      next_st.illegal_pc_load_fault = sticky(st.illegal_pc_load_fault,
                                             FAULT_EVT.illegal_pc_load,
                                             wr_fault & wd[BIT_ILL_PC]);

      // hard fault status: read normally, write one to clear
      next_st.vector_read_fault = sticky(st.vector_read_fault, FAULT_EVT.vector_read_fault,
                                         wr_hard & wd[BIT_VECT_READ]);
      next_st.forced = sticky(st.forced, FAULT_EVT.forced_escalation,
                              wr_hard & wd[BIT_FORCED]);
      // software keeps bit 31 zero on writes
      next_st.debug_reserved_flag = sticky(st.debug_reserved_flag, FAULT_EVT.debug_event,
                                           wr_hard & wd[BIT_DEBUG_RSV]);

      // entry control for the exception sequencer
      next_st.entry.valid        = any_fault;
      next_st.entry.sp_adjust    = any_fault & ~FAULT_EVT.unstack_bus_fault;
      next_st.entry.context_save = any_fault & ~FAULT_EVT.unstack_bus_fault;
      next_st.entry.hard_fault   = FAULT_EVT.vector_read_fault
                                   | FAULT_EVT.forced_escalation;
      if (FAULT_EVT.vector_read_fault) begin
         next_st.entry.return_pc = FAULT_EVT.preempt_pc;
      end else begin
         next_st.entry.return_pc = FAULT_EVT.fault_pc;
      end

      // read data, valid only in the cycle after the strobe
      next_st.rdata = RST_ZERO;
      if (BUS_REQ.rd) begin
         case (BUS_REQ.addr)
            OFS_SET_PEND: begin
               next_st.rdata = DATA_W'(st.pending);
            end
            OFS_ENABLE: begin
               next_st.rdata = DATA_W'(st.enable);
            end
            OFS_FAULT_STAT: begin
               next_st.rdata[BIT_UNSTACK_BF] = st.unstack_bf;
               next_st.rdata[BIT_STACK_BF]   = st.entry_stacking_fault;
               next_st.rdata[BIT_ADDR_VALID] = st.bus_fault_addr_valid;
               next_st.rdata[BIT_UNDEF_OP]   = st.undecodable_op_fault;
               next_st.rdata[BIT_ILL_STATE]  = st.illegal_state_fault;
               next_st.rdata[BIT_ILL_PC]     = st.illegal_pc_load_fault;
            end
            OFS_HARD_STAT: begin
               next_st.rdata[BIT_VECT_READ] = st.vector_read_fault;
               next_st.rdata[BIT_FORCED]    = st.forced;
               next_st.rdata[BIT_DEBUG_RSV] = st.debug_reserved_flag;
            end
            OFS_BUS_ADDR: begin
               next_st.rdata = st.bus_fault_address;
            end
            default: begin
               next_st.rdata = RST_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign BUS_RDATA      = st.rdata;
   assign IRQ_PENDING    = st.pending;
   assign IRQ_ACTIVE_REQ = st.pending & st.enable;
   assign ENTRY_CTL      = st.entry;

   // checks
   property p_set_pend;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (BUS_REQ.wr && BUS_REQ.addr == OFS_SET_PEND && BUS_REQ.wdata[0])
      |=> IRQ_PENDING[0];
   endproperty
   a_set_pend: assert property (p_set_pend) else $error("set pending lost");

   property p_zero_no_effect;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (BUS_REQ.wr && BUS_REQ.addr == OFS_SET_PEND && !BUS_REQ.wdata[1]
       && !IRQ_REQ[1] && !IRQ_PENDING[1]) |=> !IRQ_PENDING[1];
   endproperty
   a_zero_no_effect: assert property (p_zero_no_effect) else $error("zero set pending");

   property p_pend_read;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (BUS_REQ.rd && BUS_REQ.addr == OFS_SET_PEND)
      |=> BUS_RDATA == DATA_W'($past(IRQ_PENDING));
   endproperty
   a_pend_read: assert property (p_pend_read) else $error("pending readback wrong");

   property p_pend_hold;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (IRQ_PENDING[2] && !(IRQ_ACK && IRQ_ACK_NUM == 5'h02)) |=> IRQ_PENDING[2];
   endproperty
   a_pend_hold: assert property (p_pend_hold) else $error("pending dropped");

   property p_disabled_pend;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (BUS_REQ.wr && BUS_REQ.addr == OFS_SET_PEND && BUS_REQ.wdata[3]
       && !st.enable[3])
      |=> IRQ_PENDING[3];
   endproperty
   a_disabled_pend: assert property (p_disabled_pend) else $error("disabled not pended");

   property p_unstack_entry;
      @(posedge CORE_CLK) disable iff (!RESETN)
      FAULT_EVT.unstack_bus_fault
      |=> ENTRY_CTL.valid && !ENTRY_CTL.sp_adjust && !ENTRY_CTL.context_save;
   endproperty
   a_unstack_entry: assert property (p_unstack_entry) else $error("unstack entry wrong");

   property p_stack_flag;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (FAULT_EVT.stack_bus_fault && !FAULT_EVT.unstack_bus_fault)
      |=> st.entry_stacking_fault && ENTRY_CTL.sp_adjust;
   endproperty
   a_stack_flag: assert property (p_stack_flag) else $error("stacking fault missed");

   property p_addr_frozen;
      @(posedge CORE_CLK) disable iff (!RESETN)
      st.entry_stacking_fault |=> $stable(st.bus_fault_address);
   endproperty
   a_addr_frozen: assert property (p_addr_frozen) else $error("address updated");

   property p_addr_valid;
      @(posedge CORE_CLK) disable iff (!RESETN)
      addr_capture |=> st.bus_fault_addr_valid
                       && st.bus_fault_address == $past(FAULT_EVT.bus_addr);
   endproperty
   a_addr_valid: assert property (p_addr_valid) else $error("address valid missed");

   property p_mem_clears;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (FAULT_EVT.mem_fault && !addr_capture) |=> !st.bus_fault_addr_valid;
   endproperty
   a_mem_clears: assert property (p_mem_clears) else $error("valid not cleared");

   property p_state_suppr;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (FAULT_EVT.undef_instr && !st.illegal_state_fault)
      |=> st.undecodable_op_fault && !st.illegal_state_fault;
   endproperty
   a_state_suppr: assert property (p_state_suppr) else $error("state flag raised");

   property p_vect_pc;
      @(posedge CORE_CLK) disable iff (!RESETN)
      FAULT_EVT.vector_read_fault |=> ENTRY_CTL.hard_fault && st.vector_read_fault
                                      && ENTRY_CTL.return_pc == $past(FAULT_EVT.preempt_pc);
   endproperty
   a_vect_pc: assert property (p_vect_pc) else $error("vector fault entry wrong");

   property p_w1c;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (BUS_REQ.wr && BUS_REQ.addr == OFS_HARD_STAT && BUS_REQ.wdata[BIT_FORCED]
       && !FAULT_EVT.forced_escalation) |=> !st.forced;
   endproperty
   a_w1c: assert property (p_w1c) else $error("forced not cleared");

   property p_sticky;
      @(posedge CORE_CLK) disable iff (!RESETN)
      (st.forced && !(BUS_REQ.wr && BUS_REQ.addr == OFS_HARD_STAT)) |=> st.forced;
   endproperty
   a_sticky: assert property (p_sticky) else $error("forced flag dropped");

   c_swpend: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      wr_set_pend ##1 IRQ_ACK);
   c_stack: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      FAULT_EVT.stack_bus_fault ##1 FAULT_EVT.bus_fault_precise);
   c_clr: cover property (@(posedge CORE_CLK) disable iff (!RESETN)
      st.vector_read_fault ##1 wr_hard);
endmodule // fsp_fault_status

// *** fsp_pkg.sv ***
package fsp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_SET_PEND   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ENABLE     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FAULT_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_HARD_STAT  = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_BUS_ADDR   = 8'h10;
   // fault status field positions
   localparam int BIT_UNSTACK_BF = 0;
   localparam int BIT_STACK_BF   = 1;
   localparam int BIT_ADDR_VALID = 7;
   localparam int BIT_UNDEF_OP   = 16;
   localparam int BIT_ILL_STATE  = 17;
   localparam int BIT_ILL_PC     = 18;
   // hard fault status field positions
   localparam int BIT_VECT_READ  = 1;
   localparam int BIT_FORCED     = 30;
   localparam int BIT_DEBUG_RSV  = 31;
   // values after reset
   localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } fsp_bus_req_t;

   typedef struct packed {
      logic              unstack_bus_fault;
      logic              stack_bus_fault;
      logic              bus_fault_precise;
      logic [DATA_W-1:0] bus_addr;
      logic              mem_fault;
      logic              undef_instr;
      logic              illegal_state;
      logic              illegal_pc_load;
      logic              forced_escalation;
      logic              vector_read_fault;
      logic              debug_event;
      logic [DATA_W-1:0] fault_pc;
      logic [DATA_W-1:0] preempt_pc;
   } fsp_fault_evt_t;

   typedef struct packed {
      logic              valid;
      logic              sp_adjust;
      logic              context_save;
      logic              hard_fault;
      logic [DATA_W-1:0] return_pc;
   } fsp_entry_ctl_t;
endpackage

// *** fsp_core_model.sv ***
`timescale 1ns/1ps
module fsp_core_model (
   // clock
   input  wire logic                    CORE_CLK,
   // command from bench
   input  wire logic                    go,
   input  wire fsp_pkg::fsp_fault_evt_t cmd,
   // fault reports to the block
   output fsp_pkg::fsp_fault_evt_t      evt
);
   import fsp_pkg::*;
   initial evt = '0;
   // reports are one-cycle pulses; pcs and address wander when idle
   always @(posedge CORE_CLK) begin
      if (go) begin
         evt <= cmd;
      end else begin
         evt <= '{bus_addr:   ~evt.bus_addr,
                  fault_pc:   ~evt.fault_pc,
                  preempt_pc: evt.preempt_pc + 32'h0000_0004,
                  default:    '0};
      end
   end
endmodule // fsp_core_model

// *** fault_status_and_pending_tb.sv ***
`timescale 1ns/1ps
module fault_status_and_pending_tb;
   import fsp_pkg::*;
   logic              core_clk    = 1'b0;
   logic              resetn      = 1'b0;
   fsp_bus_req_t      bus_req     = '0;
   logic [31:0]       rdata;
   logic [31:0]       irq_req     = '0;
   logic              irq_ack     = 1'b0;
   logic [4:0]        irq_ack_num = '0;
   logic [31:0]       irq_pend;
   logic [31:0]       irq_act;
   fsp_fault_evt_t    fault_evt;
   fsp_entry_ctl_t    entry_ctl;
   logic              go          = 1'b0;
   fsp_fault_evt_t    cmd         = '0;
   logic [31:0]       exp_q[$];
   logic              rd_d        = 1'b0;
   int                fail_count  = 0;
   int                n_tests     = 0;
   logic [31:0]       fs, hs, ba, mask, en;
   logic [9:0]        list_b[9] = '{10'h080, 10'h040, 10'h280, 10'h030, 10'h010,
                                    10'h008, 10'h084, 10'h002, 10'h001};

   always #10 core_clk = ~core_clk;

   fsp_fault_status #(.NUM_IRQ(32)) uut (
      .CORE_CLK(core_clk), .RESETN(resetn), .BUS_REQ(bus_req), .BUS_RDATA(rdata),
      .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack), .IRQ_ACK_NUM(irq_ack_num),
      .IRQ_PENDING(irq_pend), .IRQ_ACTIVE_REQ(irq_act),
      .FAULT_EVT(fault_evt), .ENTRY_CTL(entry_ctl));

   fsp_core_model core (.CORE_CLK(core_clk), .go(go), .cmd(cmd), .evt(fault_evt));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_d) begin
         check(rdata, exp_q.pop_front());
      end
      rd_d <= bus_req.rd;
   end

   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{wr: w, rd: r, addr: a, wdata: d};
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, 1'b1, a, '0);
   endtask

   task automatic do_reset();
      resetn <= 1'b0;
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      fs = '0;
      hs = '0;
      ba = '0;
      // unmapped offset 0x20 included
      foreach (list_b[i]) rd(8'(i * 4 % 40), 32'h0000_0000);
      bus(1'b0, 1'b0, '0, '0);
   endtask

   function automatic fsp_fault_evt_t ev(input logic [9:0] f, input logic [31:0] a);
      ev = '0;
      {ev.unstack_bus_fault, ev.stack_bus_fault, ev.bus_fault_precise, ev.mem_fault,
       ev.undef_instr, ev.illegal_state, ev.illegal_pc_load, ev.forced_escalation,
       ev.vector_read_fault, ev.debug_event} = f;
      ev.bus_addr   = a;
      ev.fault_pc   = a ^ 32'h5A5A_5A5A;
      ev.preempt_pc = ~a;
   endfunction

   task automatic do_fault(input logic [9:0] f);
      fsp_fault_evt_t c;
      logic           v;
      logic           cap;
      c = ev(f, $urandom);
      @(posedge core_clk);
      cmd <= c;
      go  <= 1'b1;
      @(posedge core_clk);
      go  <= 1'b0;
      @(posedge core_clk);
      #1;
      v = |f[9:1];
      check(entry_ctl.valid, v);
      check(entry_ctl.sp_adjust, v & ~f[9]);
      check(entry_ctl.context_save, v & ~f[9]);
      check(entry_ctl.hard_fault, f[2] | f[1]);
      if (v) check(entry_ctl.return_pc, f[1] ? c.preempt_pc : c.fault_pc);
      cap = f[7] & ~f[8] & ~f[9] & ~fs[BIT_STACK_BF];
      if (cap) ba = c.bus_addr;
      fs[BIT_ADDR_VALID] = cap | (fs[BIT_ADDR_VALID] & ~f[6]);
      fs[BIT_UNSTACK_BF] |= f[9];
      fs[BIT_STACK_BF]   |= f[8];
      fs[BIT_UNDEF_OP]   |= f[5];
      fs[BIT_ILL_STATE]  |= f[4] & ~f[5];
      fs[BIT_ILL_PC]     |= f[3];
      hs[BIT_VECT_READ]  |= f[1];
      hs[BIT_FORCED]     |= f[2];
      hs[BIT_DEBUG_RSV]  |= f[0];
      rd(OFS_FAULT_STAT, fs);
      rd(OFS_HARD_STAT, hs);
      rd(OFS_BUS_ADDR, ba);
      bus(1'b0, 1'b0, '0, '0);
   endtask

   // handler clears what it saw; debug bit always written as zero
   task automatic clear_all();
      bus(1'b1, 1'b0, OFS_FAULT_STAT, fs);
      bus(1'b1, 1'b0, OFS_HARD_STAT, hs & 32'h7FFF_FFFF);
      fs = '0;
      hs &= 32'h8000_0000;
      rd(OFS_FAULT_STAT, fs);
      rd(OFS_HARD_STAT, hs);
      bus(1'b0, 1'b0, '0, '0);
   endtask

   initial begin
      #400000;
      fail_count++;
      final_report();
   end

   initial begin
      void'($urandom(32'h7EBB437D));
      do_reset();
      // bits 0 and 3 set while disabled, bit 1 left for the zero write
      mask = ($urandom | 32'h0000_0009) & 32'hFFFF_FFFD;
      en   = $urandom;
      bus(1'b1, 1'b0, OFS_SET_PEND, mask);
      rd(OFS_SET_PEND, mask);
      bus(1'b1, 1'b0, OFS_SET_PEND, 32'h0000_0000);
      bus(1'b1, 1'b0, OFS_SET_PEND, mask);
      bus(1'b1, 1'b0, OFS_ENABLE, en);
      rd(OFS_SET_PEND, mask);
      rd(OFS_ENABLE, en);
      bus(1'b0, 1'b0, '0, '0);
      @(posedge core_clk);
      #1;
      check(irq_pend, mask);
      check(irq_act, mask & en);
      @(posedge core_clk);
      irq_ack_num <= 5'h07;
      irq_ack     <= 1'b1;
      @(posedge core_clk);
      irq_ack     <= 1'b0;
      irq_req     <= 32'h0010_0000 | ~mask;
      @(posedge core_clk);
      irq_req     <= '0;
      mask = (mask & 32'hFFFF_FF7F) | 32'h0010_0000 | ~mask;
      rd(OFS_SET_PEND, mask);
      bus(1'b0, 1'b0, '0, '0);
      do_fault(10'h100);
      do_fault(10'h080);
      clear_all();
      foreach (list_b[i]) do_fault(list_b[i]);
      clear_all();
      do_fault(10'h3FE);
      do_reset();
      // let the last reads come back before the verdict
      repeat (3) @(posedge core_clk);
      check(exp_q.size(), 32'h0000_0000);
      final_report();
   end
endmodule // fault_status_and_pending_tb
